// ==== sle_defines.svh ====
/*
 * status lamp encoder constants: offsets, field positions, reset values, timing counts.
 * assumes a 20 MHz pclk and an APB master with 32-bit data.
 */
`ifndef SLE_DEFINES_SVH
`define SLE_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// register byte addresses
`define SLE_ADDR_CTRL 12'h000
`define SLE_ADDR_STAT 12'h004
`define SLE_ADDR_LAMP 12'h008

////////////////////////////////////////////////////////////////////////////////
// control register fields
`define SLE_CTRL_CONFIGURED 0
`define SLE_CTRL_HEALTHY 1
`define SLE_CTRL_CRASH_RESET 2
`define SLE_CTRL_DUP_ADDR 3
`define SLE_CTRL_ADDR_REQ 4
`define SLE_CTRL_DEFAULT_ADDR 5
`define SLE_CTRL_NO_EXEC 6
`define SLE_CTRL_BAD_ADDR_CFG 7
`define SLE_CTRL_KERNEL 8
`define SLE_CTRL_DOWNLOAD 9
`define SLE_CTRL_CRASH_LOG 10
`define SLE_CTRL_WIDTH 11
`define SLE_CTRL_RESET 11'h000

////////////////////////////////////////////////////////////////////////////////
// status register fields
`define SLE_STAT_LINK 0
`define SLE_STAT_SPEED_10 1
`define SLE_STAT_SPEED_100 2
`define SLE_STAT_FULL_DUPLEX 3
`define SLE_STAT_OFFLINE 4
`define SLE_STAT_CODE_LSB 8

////////////////////////////////////////////////////////////////////////////////
// flash group codes
`define SLE_CODE_STEADY 4'h0
`define SLE_CODE_NO_LINK 4'h3
`define SLE_CODE_DUP_ADDR 4'h4
`define SLE_CODE_ADDR_REQ 4'h5
`define SLE_CODE_DEFAULT_ADDR 4'h6
`define SLE_CODE_NO_EXEC 4'h7
`define SLE_CODE_BAD_ADDR_CFG 4'h8

////////////////////////////////////////////////////////////////////////////////
// timing: lamp times in ms, cycle counts derived at 20 MHz
`define SLE_CLK_HZ 20000000
`define SLE_FLASH_ON_MS 200
`define SLE_FLASH_OFF_MS 200
`define SLE_GROUP_PAUSE_MS 1000
`define SLE_STRETCH_MS 50
`define SLE_BLINK_MS 250
`define SLE_MS_CYCLES(ms) ((ms) * (`SLE_CLK_HZ / 1000))

`endif

// ==== sle_pkg.sv ====
/*
 * status lamp encoder types.
 * assumes sle_defines.svh is compiled alongside.
 */
package sle_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // run lamp sequencer states
  typedef enum logic [3:0] {
    SLE_RUN_STEADY = 4'b0001,
    SLE_RUN_ON = 4'b0010,
    SLE_RUN_OFF = 4'b0100,
    SLE_RUN_PAUSE = 4'b1000
  } sle_run_state_t;

endpackage : sle_pkg

// ==== sle_stretch.sv ====
/*
 * pulse stretcher: turns a one-cycle event into a lamp flash of fixed length.
 * assumes events synchronous to clk; presetn asynchronous active low.
 */
`timescale 1ns/1ps
module sle_stretch #(
  parameter int unsigned CYCLES = 1000000
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // event in, lamp out
  input wire logic event_in,
  output logic lamp
);

  typedef struct packed {
    logic [31:0] cnt;
    logic lamp;
  } sle_stretch_state_t;

  sle_stretch_state_t st_q;
  sle_stretch_state_t st_d;

  always_comb begin
    st_d = st_q;
    if (event_in) begin
      st_d.cnt = 32'(CYCLES - 1);
      st_d.lamp = 1'b1;
    end else if (st_q.cnt != 32'h0000_0000) begin
      st_d.cnt = st_q.cnt - 32'h0000_0001;
    end else begin
      st_d.lamp = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign lamp = st_q.lamp;

endmodule : sle_stretch

// ==== sle_top.sv ====
/*
 * status lamp encoder: front-panel lamps of an ethernet module, with an APB
 * register slave for firmware status bits and link state readback.
 * assumes physical-layer inputs synchronous to pclk; traffic events one-cycle pulses.
 */
`timescale 1ns/1ps
`include "sle_defines.svh"
module sle_top #(
  parameter int unsigned FLASH_ON_CYCLES = `SLE_MS_CYCLES(`SLE_FLASH_ON_MS),
  parameter int unsigned FLASH_OFF_CYCLES = `SLE_MS_CYCLES(`SLE_FLASH_OFF_MS),
  parameter int unsigned PAUSE_CYCLES = `SLE_MS_CYCLES(`SLE_GROUP_PAUSE_MS),
  parameter int unsigned STRETCH_CYCLES = `SLE_MS_CYCLES(`SLE_STRETCH_MS),
  parameter int unsigned BLINK_CYCLES = `SLE_MS_CYCLES(`SLE_BLINK_MS)
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // physical layer status
  input wire logic phy_link,
  input wire logic phy_speed_100,
  input wire logic phy_full_duplex,
  input wire logic phy_tx_event,
  input wire logic phy_rx_event,
  input wire logic phy_collision,
  // lamps
  output logic active_lamp,
  output logic ready_lamp,
  output logic fault_lamp,
  output logic run_lamp,
  output logic collision_lamp,
  output logic link_lamp,
  output logic send_activity_lamp,
  output logic receive_activity_lamp,
  output logic loader_lamp,
  output logic ten_megabit_lamp,
  output logic hundred_megabit_lamp,
  output logic full_two_way_lamp,
  output logic crash_record_lamp,
  // network gate
  output logic net_offline
);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [`SLE_CTRL_WIDTH-1:0] ctrl;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    sle_pkg::sle_run_state_t run_st;
    logic [3:0] code;
    logic [3:0] flashes_left;
    logic [31:0] run_cnt;
    logic [31:0] blink_cnt;
    logic blink;
    logic active;
    logic ready;
    logic fault;
    logic run;
    logic link;
    logic loader;
    logic ten;
    logic hundred;
    logic full;
    logic crash_rec;
    logic offline;
  } sle_top_state_t;

  sle_top_state_t st_q;
  sle_top_state_t st_d;

  logic tx_stretched;
  logic rx_stretched;
  logic coll_stretched;
  logic tx_q;
  logic rx_q;
  logic coll_q;

  ////////////////////////////////////////////////////////////////////////////////
  // functions

  // diagnostic code, highest-priority condition first
  function automatic logic [3:0] sle_code(input logic [`SLE_CTRL_WIDTH-1:0] c,
                                          input logic link);
    logic [3:0] r;
    r = `SLE_CODE_STEADY;
    if (c[`SLE_CTRL_NO_EXEC]) begin
      r = `SLE_CODE_NO_EXEC;
    end else if (!link) begin
      r = `SLE_CODE_NO_LINK;
    end else if (c[`SLE_CTRL_DUP_ADDR]) begin
      r = `SLE_CODE_DUP_ADDR;
    end else if (c[`SLE_CTRL_ADDR_REQ]) begin
      r = `SLE_CODE_ADDR_REQ;
    end else if (c[`SLE_CTRL_BAD_ADDR_CFG]) begin
      r = `SLE_CODE_BAD_ADDR_CFG;
    end else if (c[`SLE_CTRL_DEFAULT_ADDR]) begin
      r = `SLE_CODE_DEFAULT_ADDR;
    end
    return r;
  endfunction : sle_code

  // register decode: one-hot select of the three mapped words
  function automatic logic [2:0] sle_decode(input logic [11:0] a);
    logic [2:0] r;
    r = 3'b000;
    case (a)
      `SLE_ADDR_CTRL: begin
        r = 3'b001;
      end
      `SLE_ADDR_STAT: begin
        r = 3'b010;
      end
      `SLE_ADDR_LAMP: begin
        r = 3'b100;
      end
      default: begin
        r = 3'b000;
      end
    endcase
    return r;
  endfunction : sle_decode

  // down-counter reload value
  function automatic logic [31:0] sle_load(input int unsigned cycles);
    return 32'(cycles - 1);
  endfunction : sle_load

  ////////////////////////////////////////////////////////////////////////////////
  // traffic stretchers

  sle_stretch #(.CYCLES(STRETCH_CYCLES)) u_tx (
    .pclk(pclk),
    .presetn(presetn),
    .event_in(phy_tx_event),
    .lamp(tx_stretched)
  );

  sle_stretch #(.CYCLES(STRETCH_CYCLES)) u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .event_in(phy_rx_event),
    .lamp(rx_stretched)
  );

  sle_stretch #(.CYCLES(STRETCH_CYCLES)) u_coll (
    .pclk(pclk),
    .presetn(presetn),
    .event_in(phy_collision),
    .lamp(coll_stretched)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [3:0] code_now;
    logic setup;
    logic access;
    logic [2:0] sel;
    code_now = sle_code(st_q.ctrl, phy_link);
    setup = psel && !penable;
    access = psel && penable;
    sel = sle_decode(paddr);
    st_d = st_q;

    // apb: no wait state, pready answers in the first access cycle
    st_d.pready = 1'b0;
    st_d.pslverr = 1'b0;
    if (setup) begin
      st_d.pready = 1'b1;
      st_d.prdata = 32'h0000_0000;
      case (sel)
        3'b001: begin
          if (!pwrite) begin
            st_d.prdata[`SLE_CTRL_WIDTH-1:0] = st_q.ctrl;
          end
        end
        3'b010: begin
          if (pwrite) begin
            st_d.pslverr = 1'b1;
          end else begin
            st_d.prdata[`SLE_STAT_LINK] = phy_link;
            st_d.prdata[`SLE_STAT_SPEED_10] = st_q.ten;
            st_d.prdata[`SLE_STAT_SPEED_100] = st_q.hundred;
            st_d.prdata[`SLE_STAT_FULL_DUPLEX] = st_q.full;
            st_d.prdata[`SLE_STAT_OFFLINE] = st_q.offline;
            st_d.prdata[`SLE_STAT_CODE_LSB +: 4] = st_q.code;
          end
        end
        3'b100: begin
          if (pwrite) begin
            st_d.pslverr = 1'b1;
          end else begin
            st_d.prdata[12:0] = {st_q.active, st_q.ready, st_q.fault, st_q.run,
                                 coll_q, st_q.link, tx_q, rx_q, st_q.loader,
                                 st_q.ten, st_q.hundred, st_q.full, st_q.crash_rec};
          end
        end
        default: begin
          st_d.pslverr = 1'b1;
        end
      endcase
    end

    // write lands at the access edge, where the master samples pready;
    // refused writes (status, lamp, unmapped) never reach ctrl
    if (access && st_q.pready && pwrite && sel[0]) begin
      st_d.ctrl = pwdata[`SLE_CTRL_WIDTH-1:0];
    end

    // steady lamps
    st_d.active = st_q.ctrl[`SLE_CTRL_CONFIGURED];
    st_d.ready = st_q.ctrl[`SLE_CTRL_HEALTHY];
    st_d.fault = st_q.ctrl[`SLE_CTRL_CRASH_RESET] || st_q.ctrl[`SLE_CTRL_DUP_ADDR]
                 || !phy_link || st_q.ctrl[`SLE_CTRL_ADDR_REQ];
    st_d.link = phy_link;
    st_d.ten = phy_link && !phy_speed_100;
    st_d.hundred = phy_link && phy_speed_100;
    st_d.full = phy_link && phy_full_duplex;
    st_d.crash_rec = st_q.ctrl[`SLE_CTRL_CRASH_LOG];
    st_d.offline = st_q.ctrl[`SLE_CTRL_DUP_ADDR];

    // loader lamp: blink while downloading, steady in kernel mode
    if (st_q.blink_cnt == 32'h0000_0000) begin
      st_d.blink_cnt = sle_load(BLINK_CYCLES);
      st_d.blink = !st_q.blink;
    end else begin
      st_d.blink_cnt = st_q.blink_cnt - 32'h0000_0001;
    end
    if (st_q.ctrl[`SLE_CTRL_DOWNLOAD]) begin
      st_d.loader = st_q.blink;
    end else begin
      st_d.loader = st_q.ctrl[`SLE_CTRL_KERNEL];
    end

    // run lamp sequencer; a new code takes effect at the next group start
    if (st_q.run_cnt != 32'h0000_0000) begin
      st_d.run_cnt = st_q.run_cnt - 32'h0000_0001;
    end
    case (st_q.run_st)
      sle_pkg::SLE_RUN_STEADY: begin
        st_d.run = 1'b1;
        st_d.code = code_now;
        if (code_now != `SLE_CODE_STEADY) begin
          st_d.run_st = sle_pkg::SLE_RUN_PAUSE;
          st_d.run = 1'b0;
          st_d.run_cnt = sle_load(PAUSE_CYCLES);
        end
      end
      sle_pkg::SLE_RUN_ON: begin
        st_d.run = 1'b1;
        if (st_q.run_cnt == 32'h0000_0000) begin
          st_d.run = 1'b0;
          st_d.flashes_left = st_q.flashes_left - 4'h1;
          if (st_q.flashes_left == 4'h1) begin
            st_d.run_st = sle_pkg::SLE_RUN_PAUSE;
            st_d.run_cnt = sle_load(PAUSE_CYCLES);
          end else begin
            st_d.run_st = sle_pkg::SLE_RUN_OFF;
            st_d.run_cnt = sle_load(FLASH_OFF_CYCLES);
          end
        end
      end
      sle_pkg::SLE_RUN_OFF: begin
        st_d.run = 1'b0;
        if (st_q.run_cnt == 32'h0000_0000) begin
          st_d.run_st = sle_pkg::SLE_RUN_ON;
          st_d.run = 1'b1;
          st_d.run_cnt = sle_load(FLASH_ON_CYCLES);
        end
      end
      sle_pkg::SLE_RUN_PAUSE: begin
        st_d.run = 1'b0;
        if (st_q.run_cnt == 32'h0000_0000) begin
          st_d.code = code_now;
          if (code_now == `SLE_CODE_STEADY) begin
            st_d.run_st = sle_pkg::SLE_RUN_STEADY;
            st_d.run = 1'b1;
          end else begin
            st_d.run_st = sle_pkg::SLE_RUN_ON;
            st_d.run = 1'b1;
            st_d.flashes_left = code_now;
            st_d.run_cnt = sle_load(FLASH_ON_CYCLES);
          end
        end
      end
      default: begin
        st_d.run_st = sle_pkg::SLE_RUN_STEADY;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      st_q.ctrl <= `SLE_CTRL_RESET;
      st_q.run_st <= sle_pkg::SLE_RUN_STEADY;
      tx_q <= 1'b0;
      rx_q <= 1'b0;
      coll_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tx_q <= tx_stretched;
      rx_q <= rx_stretched;
      coll_q <= coll_stretched;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign active_lamp = st_q.active;
  assign ready_lamp = st_q.ready;
  assign fault_lamp = st_q.fault;
  assign run_lamp = st_q.run;
  assign collision_lamp = coll_q;
  assign link_lamp = st_q.link;
  assign send_activity_lamp = tx_q;
  assign receive_activity_lamp = rx_q;
  assign loader_lamp = st_q.loader;
  assign ten_megabit_lamp = st_q.ten;
  assign hundred_megabit_lamp = st_q.hundred;
  assign full_two_way_lamp = st_q.full;
  assign crash_record_lamp = st_q.crash_rec;
  assign net_offline = st_q.offline;

endmodule : sle_top

// ==== sle_top_asserts.sv ====
/* checker for the status lamp encoder: apb answer, lamp levels, stretch, run gaps.
   assumes it is bound into sle_top and sees only its ports. */
`timescale 1ns/1ps
module sle_top_asserts #(
  parameter int unsigned FLASH_OFF_CYCLES = 4,
  parameter int unsigned PAUSE_CYCLES = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // physical layer
  input wire logic phy_link,
  input wire logic phy_speed_100,
  input wire logic phy_tx_event,
  input wire logic phy_rx_event,
  input wire logic phy_collision,
  // lamps
  input wire logic fault_lamp,
  input wire logic run_lamp,
  input wire logic collision_lamp,
  input wire logic link_lamp,
  input wire logic send_activity_lamp,
  input wire logic receive_activity_lamp,
  input wire logic ten_megabit_lamp,
  input wire logic hundred_megabit_lamp
);
  int unsigned dark_q;
  logic seen_q;
  logic live_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn || !live_q);
  ////////////////////////////////////////////////////////////////////////////////
  // dark run length of the run lamp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dark_q <= 0;
      seen_q <= 1'b0;
      live_q <= 1'b0;
    end else begin
      live_q <= 1'b1;
      dark_q <= run_lamp ? 0 : dark_q + 1;
      seen_q <= seen_q | run_lamp;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  property p_apb;
    psel && !penable |=> pready;
  endproperty
  a_apb: assert property (p_apb) else $error("no answer after setup");
  property p_fault;
    !phy_link |=> fault_lamp;
  endproperty
  a_fault: assert property (p_fault) else $error("fault lamp dark without link");
  property p_link;
    1'b1 |=> link_lamp == $past(phy_link);
  endproperty
  a_link: assert property (p_link) else $error("link lamp wrong");
  property p_speed;
    1'b1 |=> {ten_megabit_lamp, hundred_megabit_lamp} ==
      $past({phy_link & !phy_speed_100, phy_link & phy_speed_100});
  endproperty
  a_speed: assert property (p_speed) else $error("speed lamps wrong");
  property p_tx;
    phy_tx_event |-> ##2 send_activity_lamp [*3];
  endproperty
  a_tx: assert property (p_tx) else $error("send flash short");
  property p_rx;
    phy_rx_event |-> ##2 receive_activity_lamp [*3];
  endproperty
  a_rx: assert property (p_rx) else $error("receive flash short");
  property p_coll;
    phy_collision |-> ##2 collision_lamp [*3];
  endproperty
  a_coll: assert property (p_coll) else $error("collision flash short");
  property p_gap;
    seen_q && $rose(run_lamp) |-> dark_q == FLASH_OFF_CYCLES || dark_q >= PAUSE_CYCLES;
  endproperty
  a_gap: assert property (p_gap) else $error("run lamp dark gap wrong");
endmodule : sle_top_asserts
bind sle_top sle_top_asserts #(.FLASH_OFF_CYCLES(FLASH_OFF_CYCLES), .PAUSE_CYCLES(PAUSE_CYCLES))
  u_chk (.pclk, .presetn, .psel, .penable, .pready, .phy_link, .phy_speed_100, .phy_tx_event,
  .phy_rx_event, .phy_collision, .fault_lamp, .run_lamp, .collision_lamp, .link_lamp,
  .send_activity_lamp, .receive_activity_lamp, .ten_megabit_lamp, .hundred_megabit_lamp);

// ==== sle_lamp_watch.sv ====
/* operator eye on the run lamp: counts the flashes of each group.
   assumes run_lamp is a level on pclk. */
`timescale 1ns/1ps
module sle_lamp_watch #(
  parameter int GAP = 7
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // lamp seen
  input wire logic run_lamp,
  // last group
  output int group_len,
  output logic group_done
);
  int dark;
  int cnt;
  logic last;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dark <= 0;
      cnt <= 0;
      last <= 1'b0;
      group_len <= 0;
      group_done <= 1'b0;
    end else begin
      last <= run_lamp;
      dark <= run_lamp ? 0 : dark + 1;
      group_done <= 1'b0;
      if (run_lamp && !last)
        cnt <= cnt + 1;
      if (!run_lamp && dark == GAP && cnt > 0) begin
        group_len <= cnt;
        group_done <= 1'b1;
        cnt <= 0;
      end
    end
  end
endmodule : sle_lamp_watch

// ==== tb.sv ====
/* bench for the status lamp encoder: apb master, lamp model, flash group watch.
   assumes sle_top with shortened lamp times and a 50 ns pclk. */
`timescale 1ns/1ps
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, traffic;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic phy_link, phy_speed_100, phy_full_duplex, group_done, net_offline;
  logic phy_tx_event, phy_rx_event, phy_collision;
  logic active_lamp, ready_lamp, fault_lamp, run_lamp, collision_lamp, link_lamp, loader_lamp;
  logic send_activity_lamp, receive_activity_lamp, ten_megabit_lamp, hundred_megabit_lamp;
  logic full_two_way_lamp, crash_record_lamp;
  logic [12:0] e;
  logic [10:0] c;
  int group_len, err_total, checks, n;
  sle_top #(.FLASH_ON_CYCLES(4), .FLASH_OFF_CYCLES(4), .PAUSE_CYCLES(16), .STRETCH_CYCLES(3),
    .BLINK_CYCLES(5)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .phy_link, .phy_speed_100, .phy_full_duplex, .phy_tx_event,
    .phy_rx_event, .phy_collision, .active_lamp, .ready_lamp, .fault_lamp, .run_lamp,
    .collision_lamp, .link_lamp, .send_activity_lamp, .receive_activity_lamp, .loader_lamp,
    .ten_megabit_lamp, .hundred_megabit_lamp, .full_two_way_lamp, .crash_record_lamp,
    .net_offline);
  sle_lamp_watch #(.GAP(7)) i_eye (.pclk, .presetn, .run_lamp, .group_len, .group_done);
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk)
    {phy_tx_event, phy_rx_event, phy_collision} <= traffic ? 3'($urandom) : 3'b000;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      stop_test();
    end
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_group;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (group_done !== 1'b1 && n < 400);
    if (group_done !== 1'b1) begin
      err_total++;
      stop_test();
    end
  endtask : wait_group
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    {phy_link, phy_speed_100, phy_full_duplex} = 3'b000;
    traffic = 1'b0;
    err_total = 0;
    checks = 0;
    void'($urandom(32'h173F74A8));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h000, 32'h0);
    chk("ctrl_reset", 32'h0, rd);
    apb(1, 12'h00C, 32'hFFFFFFFF);
    chk("unmapped_err", 32'h1, {31'h0, rerr});
    apb(1, 12'h004, 32'h1F);
    chk("ro_err", 32'h1, {31'h0, rerr});
    traffic <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      c = 11'($urandom) & 11'h5FF;
      {phy_link, phy_speed_100, phy_full_duplex} <= 3'($urandom);
      apb(1, 12'h000, {21'h0, c});
      apb(0, 12'h000, 32'h0);
      chk("ctrl", {21'h0, c}, rd);
      e = {c[0], c[1], c[2] | c[3] | c[4] | !phy_link, 2'b00, phy_link, 2'b00, c[8],
        phy_link & !phy_speed_100, phy_link & phy_speed_100, phy_link & phy_full_duplex, c[10]};
      apb(0, 12'h008, 32'h0);
      chk("lamp_reg", {19'h0, e}, {19'h0, rd[12:0] & 13'h1C9F});
      chk("lamp_pins", {19'h0, e}, {19'h0, active_lamp, ready_lamp, fault_lamp, 2'b00, link_lamp,
        2'b00, loader_lamp, ten_megabit_lamp, hundred_megabit_lamp, full_two_way_lamp,
        crash_record_lamp});
      apb(0, 12'h004, 32'h0);
      chk("stat", {27'h0, c[3], e[1], e[2], e[3], phy_link}, {27'h0, rd[4:0]});
    end
    traffic <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("quiet", 32'h0, {29'h0, send_activity_lamp, receive_activity_lamp, collision_lamp});
    for (int k = 0; k < 6; k++) begin
      phy_link <= (k != 0);
      c = 11'h003 | (k == 0 ? 11'h000 : 11'h001 << (k + 2));
      apb(1, 12'h000, {21'h0, c});
      wait_group();
      wait_group();
      chk("group", k + 3, group_len);
      chk("offline", {31'h0, k == 1}, {31'h0, net_offline});
    end
    apb(1, 12'h000, 32'h3);
    repeat (120) @(posedge pclk);
    n = 0;
    repeat (40) @(negedge pclk) n += (run_lamp !== 1'b1);
    chk("steady_dark", 0, n);
    apb(1, 12'h000, 32'h300);
    n = 0;
    repeat (30) @(negedge pclk);
    e[0] = loader_lamp;
    repeat (30) begin
      @(negedge pclk);
      n += (loader_lamp !== e[0]);
      e[0] = loader_lamp;
    end
    chk("loader_blinks", 1, n >= 5);
    stop_test();
  end
endmodule : tb
